// File: mrs_regs.svh
// register offsets, lengths and reset values of the rx length / flow control statistics group
// assumes a 16-bit classic wishbone byte address
`ifndef MRS_REGS_SVH
`define MRS_REGS_SVH

`define MRS_OFF_LEN_ERR      16'h4040
`define MRS_OFF_RESUME_RX    16'h4048
`define MRS_OFF_RESUME_TX    16'h404C
`define MRS_OFF_PAUSE_RX     16'h4050
`define MRS_OFF_PAUSE_TX     16'h4054
`define MRS_OFF_UNSUP_FC     16'h4058
`define MRS_OFF_BIN_64       16'h405C
`define MRS_OFF_BIN_127      16'h4060
`define MRS_OFF_BIN_255      16'h4064
`define MRS_OFF_BIN_511      16'h4068
`define MRS_OFF_BIN_1023     16'h406C
`define MRS_OFF_BIN_MAX      16'h4070
`define MRS_OFF_CONTROL      16'h4044

`define MRS_CTL_RX_EN_BIT    0
`define MRS_CTL_TX_EN_BIT    1
`define MRS_CTL_LPE_BIT      2

`define MRS_LEN_MIN          15'h0040
`define MRS_LEN_65           15'h0041
`define MRS_LEN_128          15'h0080
`define MRS_LEN_256          15'h0100
`define MRS_LEN_512          15'h0200
`define MRS_LEN_1024         15'h0400
`define MRS_LEN_MAX_STD      15'h05F2
`define MRS_LEN_MAX_LONG     15'h4000

`define MRS_CNT_RESET        32'h0000_0000
`define MRS_CNT_ONE          32'h0000_0001
`define MRS_CTL_RESET        3'h0
`define MRS_NUM_CNT          12

`endif

// File: mrs_pkg.sv
// types of the rx length / flow control statistics group
// assumes mrs_regs.svh is compiled alongside
`default_nettype none

package mrs_pkg;

  // one received frame, reported once at its end
  typedef struct packed {
    logic        done;
    logic [14:0] length;
    logic        passFilter;
    logic        crcOk;
    logic        missed;
    logic        isFlowCtrl;
    logic        isResume;
    logic        isPause;
    logic        fcBadOpcode;
  } mrs_rx_evt_s;

  typedef struct packed {
    logic resumeSent;
    logic pauseSent;
  } mrs_tx_evt_s;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } mrs_wb_req_s;

  typedef enum logic [1:0] {
    MRS_IDLE = 2'b01,
    MRS_ACK  = 2'b10
  } mrs_bus_e;

endpackage : mrs_pkg

`default_nettype wire

// File: mrs_stats.sv
// statistics counters: rx length errors, flow control frames, rx length histogram
// assumes rx/tx event strobes are one-cycle pulses on core_clk from the mac paths
//
// Implementation choice: the Wishbone interface to the registers.
`default_nettype none
`include "mrs_regs.svh"

module mrs_stats (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire mrs_pkg::mrs_rx_evt_s rxEvt,
  input  wire mrs_pkg::mrs_tx_evt_s txEvt,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [15:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output var  logic [31:0]         wb_dat_o,
  output var  logic                wb_ack_o
);

  localparam int NC = `MRS_NUM_CNT;

  logic [2:0]  ctl_ff;
  logic [31:0] cnt_ff [NC];
  logic [NC-1:0] incr;
  mrs_pkg::mrs_bus_e busSt_ff;

  logic rxEn;
  logic txEn;
  logic long_packet_enable;
  logic rxGood;
  logic tooShort;
  logic tooLong;
  logic binOk;
  logic [14:0] len;

  assign rxEn = ctl_ff[`MRS_CTL_RX_EN_BIT];
  assign txEn = ctl_ff[`MRS_CTL_TX_EN_BIT];
  assign long_packet_enable  = ctl_ff[`MRS_CTL_LPE_BIT];
  // length as reported, da through crc
  assign len  = rxEvt.length;

  assign tooShort = len < `MRS_LEN_MIN;
  assign tooLong  = long_packet_enable ? (len > `MRS_LEN_MAX_LONG) : (len > `MRS_LEN_MAX_STD);

  assign rxGood = rxEvt.done && rxEn && rxEvt.passFilter && rxEvt.crcOk;
  // flow frames and rx disabled skip bins
  assign binOk  = rxGood && !rxEvt.missed && !rxEvt.isFlowCtrl && !tooShort;

  always_comb
  begin
    incr = '0;
    incr[0] = rxEvt.done && rxEn && rxEvt.passFilter && (tooShort || tooLong);
    incr[1] = rxEvt.done && rxEn && rxEvt.isResume;
    incr[2] = txEvt.resumeSent && txEn;
    incr[3] = rxEvt.done && rxEn && rxEvt.isPause;
    incr[4] = txEvt.pauseSent && txEn;
    incr[5] = rxEvt.done && rxEn && rxEvt.fcBadOpcode;
    incr[6] = binOk && (len == `MRS_LEN_MIN);
    incr[7] = binOk && (len >= `MRS_LEN_65) && (len < `MRS_LEN_128);
    incr[8] = binOk && (len >= `MRS_LEN_128) && (len < `MRS_LEN_256);
    incr[9] = binOk && (len >= `MRS_LEN_256) && (len < `MRS_LEN_512);
    incr[10] = binOk && (len >= `MRS_LEN_512) && (len < `MRS_LEN_1024);
    incr[11] = binOk && (len >= `MRS_LEN_1024) && !tooLong;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++)
    begin : g_cnt
      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
          cnt_ff[gi] <= `MRS_CNT_RESET;
        else if (incr[gi])
          cnt_ff[gi] <= cnt_ff[gi] + `MRS_CNT_ONE;
      end
    end
  endgenerate

  logic req;
  assign req = wb_cyc_i && wb_stb_i && (busSt_ff == mrs_pkg::MRS_IDLE);

  // control register write
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ctl_ff <= `MRS_CTL_RESET;
    else if (req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `MRS_OFF_CONTROL))
      ctl_ff <= wb_dat_i[2:0];
  end

  logic [31:0] rdData;
  always_comb
  begin
    unique case (wb_adr_i)
      `MRS_OFF_LEN_ERR:   rdData = cnt_ff[0];
      `MRS_OFF_RESUME_RX: rdData = cnt_ff[1];
      `MRS_OFF_RESUME_TX: rdData = cnt_ff[2];
      `MRS_OFF_PAUSE_RX:  rdData = cnt_ff[3];
      `MRS_OFF_PAUSE_TX:  rdData = cnt_ff[4];
      `MRS_OFF_UNSUP_FC:  rdData = cnt_ff[5];
      `MRS_OFF_BIN_64:    rdData = cnt_ff[6];
      `MRS_OFF_BIN_127:   rdData = cnt_ff[7];
      `MRS_OFF_BIN_255:   rdData = cnt_ff[8];
      `MRS_OFF_BIN_511:   rdData = cnt_ff[9];
      `MRS_OFF_BIN_1023:  rdData = cnt_ff[10];
      `MRS_OFF_BIN_MAX:   rdData = cnt_ff[11];
      `MRS_OFF_CONTROL:   rdData = {29'h0000_0000, ctl_ff};
      default:            rdData = `MRS_CNT_RESET;
    endcase
  end

  // bus answer: ack one cycle after request, then drop
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      busSt_ff <= mrs_pkg::MRS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= `MRS_CNT_RESET;
    end
    else
    begin
      unique case (busSt_ff)
        mrs_pkg::MRS_IDLE:
        begin
          wb_ack_o <= req;
          if (req)
          begin
            busSt_ff <= mrs_pkg::MRS_ACK;
            wb_dat_o <= rdData;
          end
        end
        mrs_pkg::MRS_ACK:
        begin
          wb_ack_o <= 1'b0;
          busSt_ff <= mrs_pkg::MRS_IDLE;
        end
        default:
        begin
          wb_ack_o <= 1'b0;
          busSt_ff <= mrs_pkg::MRS_IDLE;
        end
      endcase
    end
  end

endmodule : mrs_stats

`default_nettype wire

// File: mrs_stats_chk.sv
// checker of the mrs_stats wishbone slave
// bound to every mrs_stats instance
`default_nettype none
module mrs_stats_chk (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rdDone;
    wb_ack_o ##0 $past(!wb_we_i);
  endsequence
  chk_ack_follow: assert property (taken |=> wb_ack_o) else $error("no ack");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  chk_idle_quiet: assert property (!wb_stb_i |=> !wb_ack_o) else $error("idle ack");
  chk_hold_data: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("data moved");
  chk_unmapped_zero:
    assert property (rdDone ##0 $past(wb_adr_i) > 16'h4070 |-> wb_dat_o == 32'h0) else $error("unmapped");
  chk_ctl_upper:
    assert property (rdDone ##0 $past(wb_adr_i) == 16'h4044 |-> wb_dat_o[31:3] == 29'h0) else $error("ctl");
  chk_rst_clear:
    assert property (disable iff (1'b0) !rst_n |=> !wb_ack_o && wb_dat_o == 32'h0) else $error("reset");
endmodule : mrs_stats_chk
bind mrs_stats mrs_stats_chk chk (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o);
`default_nettype wire

// File: mrs_stats_tb.sv
// bench of mrs_stats: counters and bins read over wishbone
// assumes mrs_pkg, mrs_stats, mrs_stats_chk compiled first
`default_nettype none
module mrs_stats_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 core_clk, rst_n, cyc, stb, we, ack;
  logic [15:0]          adr;
  logic [31:0]          wdat, rdat;
  logic [2:0]           ctl;
  mrs_pkg::mrs_rx_evt_s rx;
  mrs_pkg::mrs_tx_evt_s tx;
  logic [31:0]          cnt [12];
  logic [31:0]          q [$];
  logic [14:0]          lens [15];
  logic [6:0]           kinds [7];
  int                   seed, k, failures, nTests, cycles;
  mrs_stats DUT (.core_clk, .rst_n, .rxEvt(rx), .txEvt(tx), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // timeout and read monitor
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      finish_test();
    end
    if (ack === 1'b1 && we === 1'b0)
    begin
      nTests++;
      if (rdat !== q[0])
      begin
        failures++;
        $display("Error %0t got %h exp %h", $time, rdat, q[0]);
      end
      void'(q.pop_front());
    end
  end
  function automatic logic [15:0] addr(input int i);
    return i == 0 ? 16'h4040 : 16'h4044 + 16'(4 * i);
  endfunction : addr
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge core_clk);
    while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  task automatic rdall();
    for (int i = 0; i < 13; i++)
    begin
      q.push_back(i < 12 ? cnt[i] : 32'h0);
      wb(1'b0, i < 12 ? addr(i) : 16'h4080, 32'h0);
    end
    q.push_back({29'h0, ctl});
    wb(1'b0, 16'h4044, 32'h0);
  endtask : rdall
  task automatic pkt(input logic [14:0] len, input logic [6:0] f);
    logic [1:0] t;
    logic       ov;
    t = 2'($random(seed));
    ov = len > (ctl[2] ? 15'h4000 : 15'h05F2);
    rx <= {1'b1, len, f};
    tx <= t;
    @(posedge core_clk);
    rx <= '0;
    tx <= '0;
    @(posedge core_clk);
    if (ctl[0] && f[6] && (len < 15'h0040 || ov))
      cnt[0]++;
    if (ctl[0])
    begin
      cnt[1] += 32'(f[2]);
      cnt[3] += 32'(f[1]);
      cnt[5] += 32'(f[0]);
    end
    if (ctl[1])
    begin
      cnt[2] += 32'(t[1]);
      cnt[4] += 32'(t[0]);
    end
    if (ctl[0] && f[6:3] == 4'hC && len >= 15'h0040 && !ov)
      cnt[len < 15'h0041 ? 6 : len < 15'h0080 ? 7 : len < 15'h0100 ? 8 : len < 15'h0200 ? 9 :
        len < 15'h0400 ? 10 : 11]++;
  endtask : pkt
  task automatic finish_test();
    $display("failures %0d checks %0d", failures, nTests);
    if (failures == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  initial
  begin
    seed = 94587;
    {rst_n, cyc, stb, we, adr, wdat, ctl, rx, tx} = '0;
    foreach (cnt[i]) cnt[i] = 32'h0;
    lens = '{15'h003F, 15'h0040, 15'h0041, 15'h007F, 15'h0080, 15'h00FF, 15'h0100, 15'h01FF,
      15'h0200, 15'h03FF, 15'h0400, 15'h05F2, 15'h05F3, 15'h4000, 15'h4001};
    kinds = '{7'h60, 7'h40, 7'h70, 7'h20, 7'h6C, 7'h6A, 7'h69};
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rdall();
    for (int i = 0; i < 12; i++)
      wb(1'b1, addr(i), $random(seed));
    for (int c = 0; c < 8; c++)
    begin
      ctl = 3'(c);
      wb(1'b1, 16'h4044, {29'h0, ctl});
      foreach (lens[i])
        pkt(lens[i], 7'h60);
      repeat (20)
      begin
        k = $unsigned($random(seed)) % 7;
        pkt(k > 3 ? 15'h0040 : 15'($unsigned($random(seed)) % 1700), kinds[k]);
      end
      rdall();
    end
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    ctl = 3'h0;
    foreach (cnt[i]) cnt[i] = 32'h0;
    rdall();
    finish_test();
  end
endmodule : mrs_stats_tb
`default_nettype wire
